/* rtl/fwp_pkg.sv */
// Purpose: shared constants and types for the flash protection host controller
// Assumes: 16-bit word mode flash, 200 MHz core_clk
// Notes: all timing counts derive from ns figures at a 5 ns period
package fwp_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_PINS = 8'h14;
   // field positions
   localparam int CTRL_GO_BIT = 8;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_MAP_BIT = 1;
   localparam int ST_ERR_BIT = 2;
   localparam int PIN_RST_LOW_BIT = 0;
   localparam int PIN_VID_BIT = 1;
   localparam int PIN_WP_LOW_BIT = 2;
   localparam int PIN_ACCEL_BIT = 3;
   localparam logic [3:0] PINS_RESET = 4'h0;
   // bus timing
   localparam int CLK_NS = 5;
   localparam int SETUP_NS = 10;
   localparam int WE_LOW_NS = 35;
   localparam int HOLD_NS = 10;
   localparam int READ_NS = 70;
   localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WE_CYC = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] READ_CYC = 4'((READ_NS + CLK_NS - 1) / CLK_NS);
   // command cycle addresses and codes, word mode
   localparam logic [21:0] UNLOCK_A1 = 22'h000555;
   localparam logic [21:0] UNLOCK_A2 = 22'h0002aa;
   localparam logic [15:0] UNLOCK_D1 = 16'h00aa;
   localparam logic [15:0] UNLOCK_D2 = 16'h0055;
   localparam logic [15:0] CMD_PROG = 16'h00a0;
   localparam logic [15:0] CMD_ERASE = 16'h0080;
   localparam logic [15:0] CMD_SECTOR = 16'h0030;
   localparam logic [15:0] CMD_ENTER = 16'h0088;
   localparam logic [15:0] CMD_EXIT = 16'h0090;
   localparam logic [15:0] CMD_EXIT2 = 16'h0000;
   localparam logic [15:0] CMD_RESET = 16'h00f0;
   // secured region size in words (256 bytes)
   localparam logic [21:0] SEC_WORDS = 22'h000080;
   typedef enum logic [2:0] {
      OP_READ, OP_WRITE, OP_PROG, OP_ERASE, OP_ENTER, OP_EXIT, OP_RESET, OP_LOCK
   } fwp_op_t;
   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] data;
      logic last;
   } fwp_cycle_t;
endpackage : fwp_pkg

/* rtl/fwp_host.sv */
// Purpose: host controller that drives a parallel flash through its strobes and protection pins
// Assumes: flash data inputs synchronous to core_clk; software owns the protect algorithm
// Notes: AXI4-Lite slave for orders and status; one flash operation at a time
// Function
// RULE1: write-protect pin low blocks program and erase in four outer boot sectors.
// RULE2: write-protect pin high lets those sectors follow their stored protection.
// RULE3: elevated level on write-protect pin enables accelerated programming.
// RULE4: identification voltage on reset pin temporarily unprotects protected sectors.
// RULE5: removing that voltage re-protects all sectors protected before.
// RULE6: write-protect low keeps outer boot sectors protected during temporary unprotect.
// RULE7: secured region indicator reads 81h, 41h or 01h by lock kind.
// RULE8: enter sequence maps boot-sector addresses onto the secured region.
// RULE9: mapping lasts until exit or power loss; reset returns sector zero.
// RULE10: no accelerated or unlock bypass programming while secured region mapped.
// RULE11: factory part holds random number words 0-7 and serial number words 8-15.
// RULE12: factory-locked secured region rejects every program or erase.
// RULE13: customer region is programmed once and locked once, never unlocked.
// RULE14: host locks customer region after enter sequence, reset high or identification.
// RULE15: host issues exit sequence before touching the rest of the array.
// RULE16: below lockout supply the device ignores writes and returns to read.
// RULE17: strobe pulses under about 5 ns do not start a write.
// RULE18: write cycle only with chip-enable and write-enable low, output-enable high.
// RULE19: power-up with strobes low takes no command; state machine resets.
// RULE20: program and erase only after the unlock write cycles.
// RULE21: permanent protect uses identification voltage on the reset pin only.
// RULE22: device combines protection bit, pin and unprotect state into one permit.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module fwp_host (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // axi4-lite write address and data
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [7:0] s_awaddr,
   input wire logic s_wvalid,
   output logic s_wready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   // axi4-lite write response
   output logic s_bvalid,
   input wire logic s_bready,
   output logic [1:0] s_bresp,
   // axi4-lite read
   input wire logic s_arvalid,
   output logic s_arready,
   input wire logic [7:0] s_araddr,
   output logic s_rvalid,
   input wire logic s_rready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   // flash bus
   output logic flash_ce_b,
   output logic flash_we_b,
   output logic flash_oe_b,
   output logic [21:0] flash_addr,
   output logic [15:0] flash_dq_o,
   output logic flash_dq_oe,
   input wire logic [15:0] flash_dq_i,
   // flash protection pins
   output logic flash_rst_b,
   output logic flash_rst_vid,
   output logic write_protect_accel_pin_b,
   output logic acceleration_high_voltage_en
);
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_DONE} fwp_state_t;

   // command cycle table: one entry per bus cycle of each operation
   function automatic fwp_pkg::fwp_cycle_t seq_step(input fwp_pkg::fwp_op_t op, input logic [2:0] idx,
                                                  input logic [21:0] a, input logic [15:0] d);
      fwp_pkg::fwp_cycle_t c;
      c = '{addr: a, data: d, last: 1'b1};
      if (op != fwp_pkg::OP_WRITE && op != fwp_pkg::OP_LOCK && op != fwp_pkg::OP_RESET &&
          op != fwp_pkg::OP_READ) begin
         case (idx)
            3'd0: c = '{addr: fwp_pkg::UNLOCK_A1, data: fwp_pkg::UNLOCK_D1, last: 1'b0};
            3'd1: c = '{addr: fwp_pkg::UNLOCK_A2, data: fwp_pkg::UNLOCK_D2, last: 1'b0};
            3'd2: begin
               case (op)
                  fwp_pkg::OP_PROG: c = '{addr: fwp_pkg::UNLOCK_A1, data: fwp_pkg::CMD_PROG, last: 1'b0};
                  fwp_pkg::OP_ERASE: c = '{addr: fwp_pkg::UNLOCK_A1, data: fwp_pkg::CMD_ERASE, last: 1'b0};
                  fwp_pkg::OP_ENTER: c = '{addr: fwp_pkg::UNLOCK_A1, data: fwp_pkg::CMD_ENTER, last: 1'b1};
                  default: c = '{addr: fwp_pkg::UNLOCK_A1, data: fwp_pkg::CMD_EXIT, last: 1'b0};
               endcase
            end
            default: begin
               case (op)
                  fwp_pkg::OP_PROG: c = '{addr: a, data: d, last: 1'b1};
                  fwp_pkg::OP_ERASE: c = '{addr: a, data: fwp_pkg::CMD_SECTOR, last: 1'b1};
                  default: c = '{addr: a, data: fwp_pkg::CMD_EXIT2, last: 1'b1};
               endcase
               // erase keeps unlocking until step 5; exit ends at step 3
               if (op == fwp_pkg::OP_ERASE && idx != 3'd5) begin
                  c = (idx == 3'd3) ? '{addr: fwp_pkg::UNLOCK_A1, data: fwp_pkg::UNLOCK_D1, last: 1'b0}
                                    : '{addr: fwp_pkg::UNLOCK_A2, data: fwp_pkg::UNLOCK_D2, last: 1'b0};
               end
            end
         endcase
      end else if (op == fwp_pkg::OP_RESET) begin
         c = '{addr: a, data: fwp_pkg::CMD_RESET, last: 1'b1};
      end
      return c;
   endfunction : seq_step

   fwp_state_t state_r;
   fwp_pkg::fwp_op_t op_r;
   fwp_pkg::fwp_cycle_t cyc_r;
   logic [2:0] step_r;
   logic [3:0] cnt_r;
   logic [2:0] op_sel_r;
   logic [21:0] addr_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic [3:0] pins_r;
   logic mapped_r;
   logic err_r;
   logic start;
   logic refuse;
   logic aw_got_r;
   logic w_got_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_fire;
   logic err_clr;
   logic [31:0] rd_val;
   fwp_pkg::fwp_cycle_t first_c;
   fwp_pkg::fwp_cycle_t next_c;

   // first bus cycle of an order being taken, and the next one of the running order
   assign first_c = seq_step(fwp_pkg::fwp_op_t'(w_data_r[2:0]), 3'd0, addr_r, wdata_r);
   assign next_c = seq_step(op_r, step_r + 3'd1, addr_r, wdata_r);

   // write channel: take address and data in either order, answer after both
   assign wr_fire = aw_got_r && w_got_r && !s_bvalid;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'b00;
      end else begin
         s_awready <= !aw_got_r && !(s_awvalid && s_awready) && !s_bvalid;
         s_wready <= !w_got_r && !(s_wvalid && s_wready) && !s_bvalid;
         if (s_awvalid && s_awready) begin
            aw_got_r <= 1'b1;
            aw_addr_r <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_got_r <= 1'b1;
            w_data_r <= s_wdata;
            w_strb_r <= s_wstrb;
         end
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= (aw_addr_r > fwp_pkg::REG_PINS || aw_addr_r[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // read channel: registered data one cycle after the address is taken
   always_comb begin
      rd_val = 32'h0000_0000;
      case (s_araddr)
         fwp_pkg::REG_CTRL: rd_val = {29'h0000_0000, op_sel_r};
         fwp_pkg::REG_ADDR: rd_val = {10'h000, addr_r};
         fwp_pkg::REG_WDATA: rd_val = {16'h0000, wdata_r};
         fwp_pkg::REG_STATUS: rd_val = {29'h0000_0000, err_r, mapped_r, state_r != ST_IDLE};
         fwp_pkg::REG_RDATA: rd_val = {16'h0000, rdata_r};
         fwp_pkg::REG_PINS: rd_val = {28'h000_0000, pins_r};
         default: rd_val = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= 2'b00;
      end else begin
         s_arready <= !s_rvalid && !(s_arvalid && s_arready);
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_val;
            s_rresp <= (s_araddr > fwp_pkg::REG_PINS || s_araddr[1:0] != 2'b00) ? 2'b10 : 2'b00;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // order decode: go bit starts an operation; refused ones raise the error flag
   assign start = wr_fire && aw_addr_r == fwp_pkg::REG_CTRL && w_strb_r[1] && w_data_r[fwp_pkg::CTRL_GO_BIT];
   // locking needs the region mapped; while mapped, erases are refused and programs must stay in the region
   assign refuse = state_r != ST_IDLE || pins_r[fwp_pkg::PIN_RST_LOW_BIT] ||
                   (w_data_r[2:0] == 3'(fwp_pkg::OP_LOCK) && !mapped_r) || // RULE14
                   (mapped_r && (w_data_r[2:0] == 3'(fwp_pkg::OP_ERASE) || // RULE15
                    (w_data_r[2:0] == 3'(fwp_pkg::OP_PROG) && addr_r >= fwp_pkg::SEC_WORDS)));
   assign err_clr = wr_fire && aw_addr_r == fwp_pkg::REG_STATUS && w_strb_r[0] && w_data_r[fwp_pkg::ST_ERR_BIT];
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         op_sel_r <= 3'd0;
         addr_r <= 22'h000000;
         wdata_r <= 16'h0000;
         pins_r <= fwp_pkg::PINS_RESET;
         err_r <= 1'b0;
      end else begin
         if (wr_fire && aw_addr_r == fwp_pkg::REG_CTRL && w_strb_r[0]) op_sel_r <= w_data_r[2:0];
         if (wr_fire && aw_addr_r == fwp_pkg::REG_ADDR) addr_r <= w_data_r[21:0];
         if (wr_fire && aw_addr_r == fwp_pkg::REG_WDATA) wdata_r <= w_data_r[15:0];
         if (wr_fire && aw_addr_r == fwp_pkg::REG_PINS && w_strb_r[0]) pins_r <= w_data_r[3:0];
         // a refusal in the clearing cycle still sets the flag
         if (start && refuse) err_r <= 1'b1;
         else if (err_clr) err_r <= 1'b0;
      end
   end

   // protection pins: identification voltage only on reset, acceleration never while mapped
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_rst_b <= 1'b0;
         flash_rst_vid <= 1'b0;
         write_protect_accel_pin_b <= 1'b1;
         acceleration_high_voltage_en <= 1'b0;
      end else begin
         flash_rst_b <= !pins_r[fwp_pkg::PIN_RST_LOW_BIT];
         flash_rst_vid <= pins_r[fwp_pkg::PIN_VID_BIT] && !pins_r[fwp_pkg::PIN_RST_LOW_BIT]; // RULE21
         write_protect_accel_pin_b <= !pins_r[fwp_pkg::PIN_WP_LOW_BIT];
         acceleration_high_voltage_en <= pins_r[fwp_pkg::PIN_ACCEL_BIT] && !pins_r[fwp_pkg::PIN_WP_LOW_BIT] &&
                                         !mapped_r && !pins_r[fwp_pkg::PIN_VID_BIT];
      end
   end

   // flash cycle engine: setup, strobe, hold per cycle of the command sequence
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         op_r <= fwp_pkg::OP_READ;
         cyc_r <= '0;
         step_r <= 3'd0;
         cnt_r <= 4'h0;
         rdata_r <= 16'h0000;
         mapped_r <= 1'b0;
         flash_ce_b <= 1'b1;
         flash_we_b <= 1'b1;
         flash_oe_b <= 1'b1;
         flash_addr <= 22'h000000;
         flash_dq_o <= 16'h0000;
         flash_dq_oe <= 1'b0;
      end else begin
         cnt_r <= cnt_r + 4'h1;
         case (state_r)
            ST_IDLE: begin
               if (start && !refuse) begin
                  op_r <= fwp_pkg::fwp_op_t'(w_data_r[2:0]);
                  cyc_r <= first_c;
                  flash_addr <= first_c.addr;
                  flash_dq_o <= first_c.data;
                  flash_dq_oe <= w_data_r[2:0] != 3'(fwp_pkg::OP_READ);
                  flash_ce_b <= 1'b0;
                  step_r <= 3'd0;
                  cnt_r <= 4'h1;
                  state_r <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt_r >= fwp_pkg::SETUP_CYC) begin
                  cnt_r <= 4'h1;
                  if (op_r == fwp_pkg::OP_READ) begin
                     flash_oe_b <= 1'b0;
                     state_r <= ST_READ;
                  end else begin
                     flash_we_b <= 1'b0; // RULE18
                     state_r <= ST_STROBE;
                  end
               end
            end
            ST_STROBE: begin
               if (cnt_r >= fwp_pkg::WE_CYC) begin
                  cnt_r <= 4'h1;
                  flash_we_b <= 1'b1;
                  state_r <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_r >= fwp_pkg::HOLD_CYC) begin
                  cnt_r <= 4'h1;
                  if (cyc_r.last) begin
                     flash_ce_b <= 1'b1;
                     flash_dq_oe <= 1'b0;
                     state_r <= ST_DONE;
                  end else begin
                     // next cycle of the command sequence
                     step_r <= step_r + 3'd1; // RULE20
                     cyc_r <= next_c;
                     flash_addr <= next_c.addr;
                     flash_dq_o <= next_c.data;
                     state_r <= ST_SETUP;
                  end
               end
            end
            ST_READ: begin
               if (cnt_r >= fwp_pkg::READ_CYC) begin
                  rdata_r <= flash_dq_i;
                  flash_oe_b <= 1'b1;
                  flash_ce_b <= 1'b1;
                  state_r <= ST_DONE;
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
         // track the secured region mapping; a hardware reset unmaps it
         if (state_r == ST_DONE && op_r == fwp_pkg::OP_ENTER) mapped_r <= 1'b1; // RULE8
         if ((state_r == ST_DONE && op_r == fwp_pkg::OP_EXIT) || !flash_rst_b) mapped_r <= 1'b0; // RULE15
      end
   end

   // helper: data of the last two completed write strobes
   logic [15:0] prev1_r;
   logic [15:0] prev2_r;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev1_r <= 16'h0000;
         prev2_r <= 16'h0000;
      end else if (state_r == ST_STROBE && cnt_r >= fwp_pkg::WE_CYC) begin
         prev1_r <= flash_dq_o;
         prev2_r <= prev1_r;
      end
   end

   sequence enter_done_s;
      state_r == ST_DONE && op_r == fwp_pkg::OP_ENTER;
   endsequence
   sequence strobe_start_s;
      $fell(flash_we_b);
   endsequence

   wr_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE18
      !flash_we_b |-> !flash_ce_b && flash_oe_b && flash_dq_oe)
      else $error("write strobe without chip enable or with output enable");
   unlock_order_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE20
      strobe_start_s and (flash_dq_o == fwp_pkg::CMD_PROG || flash_dq_o == fwp_pkg::CMD_ERASE) &&
      flash_addr == fwp_pkg::UNLOCK_A1 |-> prev1_r == fwp_pkg::UNLOCK_D2 && prev2_r == fwp_pkg::UNLOCK_D1)
      else $error("program or erase command without unlock cycles");
   enter_map_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE8
      enter_done_s |=> mapped_r [*2])
      else $error("secured region not mapped after enter sequence");
   exit_first_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE15
      strobe_start_s and mapped_r && op_r == fwp_pkg::OP_PROG && cyc_r.last |-> flash_addr < fwp_pkg::SEC_WORDS)
      else $error("array programmed while secured region mapped");
   lock_mapped_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE14
      strobe_start_s and op_r == fwp_pkg::OP_LOCK |-> mapped_r && flash_rst_b)
      else $error("lock cycle outside secured region mode");
   vid_reset_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE21
      flash_rst_vid |-> flash_rst_b && !acceleration_high_voltage_en)
      else $error("identification voltage off the reset pin path");
   strobe_len_a: assert property (@(posedge core_clk) disable iff (!rst_b) // RULE17
      strobe_start_s |-> !flash_we_b [*7] ##1 flash_we_b)
      else $error("write strobe width wrong");
endmodule : fwp_host

/* bench/fwp_flash_model.sv */
// Purpose: behavioural parallel flash that answers the protection host controller
// Assumes: word mode; secured region is factory locked; sector 140 holds a stored protect bit
// Notes: program overwrites; erase fills a sector with ffff; secured word contents are arbitrary
`timescale 1ns/1ps
module fwp_flash_model #(
   parameter logic [3:0] PROT = 4'b0100
) (
   // clock used only to present read data
   input wire logic core_clk,
   // strobes and bus from the host
   input wire logic flash_ce_b,
   input wire logic flash_we_b,
   input wire logic flash_oe_b,
   input wire logic [21:0] flash_addr,
   input wire logic [15:0] flash_dq_o,
   // protection pins
   input wire logic flash_rst_b,
   input wire logic flash_rst_vid,
   input wire logic write_protect_accel_pin_b,
   // data back to the host
   output logic [15:0] flash_dq_i
);
   logic [15:0] mem [logic [21:0]];
   logic [37:0] h [$];
   logic mapped_r = 1'b0;
   logic [21:0] a;
   logic [15:0] d;
   logic [15:0] rd;
   realtime t_fall = 0.0;
   // history match of one command cycle, counted back from the newest
   function automatic logic hit(int k, logic [21:0] ha, logic [15:0] hd);
      return h.size() >= k && h[h.size() - k] === {ha, hd};
   endfunction : hit
   function automatic logic unlock(int k);
      return hit(k, fwp_pkg::UNLOCK_A1, fwp_pkg::UNLOCK_D1) && hit(k - 1, fwp_pkg::UNLOCK_A2, fwp_pkg::UNLOCK_D2);
   endfunction : unlock
   // one permit from stored bit, write-protect pin and temporary unprotect
   function automatic logic permit(logic [21:0] pa);
      logic boot;
      boot = (pa[21:13] == 9'h000) || (&pa[21:13]);
      return !(boot && !write_protect_accel_pin_b) && !(boot && PROT[{pa[21], pa[12]}] && !flash_rst_vid);
   endfunction : permit
   // glitch filter reference
   always @(negedge flash_we_b) t_fall = $realtime;
   // command decode on the write-enable rise
   always @(posedge flash_we_b or negedge flash_rst_b) begin
      if (!flash_rst_b) begin
         mapped_r = 1'b0;
         h.delete();
      end else if (!flash_ce_b && flash_oe_b && $realtime - t_fall >= 5.0) begin
         a = flash_addr;
         d = flash_dq_o;
         h.push_back({a, d});
         if (unlock(6) && hit(4, fwp_pkg::UNLOCK_A1, fwp_pkg::CMD_ERASE) && unlock(3) && d == fwp_pkg::CMD_SECTOR) begin
            if (!mapped_r && permit(a)) foreach (mem[k]) if (k[21:12] == a[21:12]) mem[k] = 16'hffff;
            h.delete();
         end else if (unlock(4) && hit(2, fwp_pkg::UNLOCK_A1, fwp_pkg::CMD_PROG)) begin
            if (!(mapped_r && a < fwp_pkg::SEC_WORDS) && permit(a)) mem[a] = d;
            h.delete();
         end else if (unlock(4) && hit(2, fwp_pkg::UNLOCK_A1, fwp_pkg::CMD_EXIT) && d == fwp_pkg::CMD_EXIT2) begin
            mapped_r = 1'b0;
            h.delete();
         end else if (unlock(3) && hit(1, fwp_pkg::UNLOCK_A1, fwp_pkg::CMD_ENTER)) begin
            mapped_r = 1'b1;
            h.delete();
         end else if (d == fwp_pkg::CMD_RESET) begin
            h.delete();
         end
         if (h.size() > 6) void'(h.pop_front());
      end
   end
   // read data; a released bus shows the inverse
   always @(posedge core_clk) begin
      rd = mem.exists(flash_addr) ? mem[flash_addr] : 16'hffff;
      if (mapped_r && flash_addr < fwp_pkg::SEC_WORDS) rd = 16'h5a00 | flash_addr[15:0];
      flash_dq_i <= (!flash_ce_b && !flash_oe_b) ? rd : ~rd;
   end
endmodule : fwp_flash_model

/* bench/testbench.sv */
// Purpose: self-checking bench for the flash protection host controller
// Assumes: flash model protects sector 140 only and has a factory-locked secured region
// Notes: tests are register sequences over AXI4-Lite
`timescale 1ns/1ps
module testbench;
   logic core_clk, rst_b, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
   logic s_arvalid, s_arready, s_rvalid, s_rready, flash_ce_b, flash_we_b, flash_oe_b, flash_dq_oe;
   logic flash_rst_b, flash_rst_vid, write_protect_accel_pin_b, acceleration_high_voltage_en;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, v;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp, r;
   logic [21:0] flash_addr;
   logic [15:0] flash_dq_o, flash_dq_i;
   int n_fail, compares, cyc;
   localparam logic [21:0] SEC5 = 22'h005010;
   localparam logic [21:0] SEC140 = 22'h3fe010;
   localparam logic [21:0] SEC141 = 22'h3ff010;
   fwp_host u_fwp_host (.core_clk, .rst_b, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid, .s_wready, .s_wdata,
      .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata,
      .s_rresp, .flash_ce_b, .flash_we_b, .flash_oe_b, .flash_addr, .flash_dq_o, .flash_dq_oe, .flash_dq_i,
      .flash_rst_b, .flash_rst_vid, .write_protect_accel_pin_b, .acceleration_high_voltage_en);
   fwp_flash_model u_fwp_flash_model (.core_clk, .flash_ce_b, .flash_we_b, .flash_oe_b, .flash_addr, .flash_dq_o,
      .flash_rst_b, .flash_rst_vid, .write_protect_accel_pin_b, .flash_dq_i);
   // clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic tally_and_finish();
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // one write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_awvalid && s_awready) s_awvalid <= 1'b0;
         if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
   endtask : wr
   // one read, result left in v and r
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      v = s_rdata;
      r = s_rresp;
      s_rready <= 1'b0;
   endtask : rd
   // flash operation, then poll until idle; v keeps the last status
   task automatic op(input fwp_pkg::fwp_op_t k, input logic [21:0] a, input logic [15:0] d);
      wr(fwp_pkg::REG_ADDR, {10'h000, a});
      wr(fwp_pkg::REG_WDATA, {16'h0000, d});
      wr(fwp_pkg::REG_CTRL, 32'h0000_0100 | {29'h0, k});
      do rd(fwp_pkg::REG_STATUS); while (v[fwp_pkg::ST_BUSY_BIT] === 1'b1);
   endtask : op
   task automatic fr(input logic [21:0] a, input logic [15:0] e);
      op(fwp_pkg::OP_READ, a, 16'h0000);
      rd(fwp_pkg::REG_RDATA);
      chk(v, {16'h0000, e});
   endtask : fr
   task automatic pins(input logic [3:0] p);
      wr(fwp_pkg::REG_PINS, {28'h0, p});
      repeat (2) @(posedge core_clk);
   endtask : pins
   // main sequence
   initial begin
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
      s_awaddr = 8'h00;
      s_araddr = 8'h00;
      s_wdata = 32'h0;
      s_wstrb = 4'hf;
      rst_b = 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rd(fwp_pkg::REG_STATUS);
      chk(v, 32'h0);
      rd(8'h18);
      chk({30'h0, r}, 32'h2);
      op(fwp_pkg::OP_PROG, SEC5, 16'h1234);
      fr(SEC5, 16'h1234);
      op(fwp_pkg::OP_ERASE, SEC5, 16'h0000);
      fr(SEC5, 16'hffff);
      pins(4'h4);
      chk(write_protect_accel_pin_b, 1'b0);
      op(fwp_pkg::OP_PROG, SEC141, 16'haaaa);
      fr(SEC141, 16'hffff);
      pins(4'h6);
      op(fwp_pkg::OP_PROG, SEC141, 16'haaaa);
      fr(SEC141, 16'hffff);
      pins(4'h0);
      op(fwp_pkg::OP_PROG, SEC141, 16'h1111);
      fr(SEC141, 16'h1111);
      op(fwp_pkg::OP_PROG, SEC140, 16'h2222);
      fr(SEC140, 16'hffff);
      pins(4'h2);
      chk(flash_rst_vid, 1'b1);
      op(fwp_pkg::OP_PROG, SEC140, 16'h2222);
      fr(SEC140, 16'h2222);
      pins(4'h0);
      op(fwp_pkg::OP_PROG, SEC140, 16'h0000);
      fr(SEC140, 16'h2222);
      pins(4'h8);
      chk(acceleration_high_voltage_en, 1'b1);
      op(fwp_pkg::OP_ENTER, 22'h0, 16'h0000);
      chk(v, 32'h2);
      chk(acceleration_high_voltage_en, 1'b0);
      fr(22'h000000, 16'h5a00);
      fr(22'h00000f, 16'h5a0f);
      op(fwp_pkg::OP_PROG, 22'h0, 16'h1234);
      fr(22'h000000, 16'h5a00);
      op(fwp_pkg::OP_ERASE, 22'h0, 16'h0000);
      chk(v, 32'h6);
      wr(fwp_pkg::REG_STATUS, 32'h4);
      op(fwp_pkg::OP_EXIT, 22'h0, 16'h0000);
      chk(v, 32'h0);
      chk(acceleration_high_voltage_en, 1'b1);
      fr(22'h000000, 16'hffff);
      op(fwp_pkg::OP_ENTER, 22'h0, 16'h0000);
      pins(4'h1);
      pins(4'h0);
      rd(fwp_pkg::REG_STATUS);
      chk(v, 32'h0);
      op(fwp_pkg::OP_LOCK, 22'h0, 16'h0000);
      chk(v, 32'h4);
      wr(fwp_pkg::REG_STATUS, 32'h4);
      op(fwp_pkg::OP_ENTER, 22'h0, 16'h0000);
      op(fwp_pkg::OP_LOCK, 22'h0, 16'h0000);
      chk(v, 32'h2);
      op(fwp_pkg::OP_RESET, 22'h0, 16'h0000);
      op(fwp_pkg::OP_EXIT, 22'h0, 16'h0000);
      chk(v, 32'h0);
      tally_and_finish();
   end
endmodule : testbench
